// ==== hw/gpb_pkg.sv ====
// package: codes, addresses, resets and timing
package gpb_pkg;
  localparam int NPINS = 8;
  localparam int PIN_BOOT = 5;
  localparam int PIN_SWD = 4;
  localparam int PIN_MISO = 1;
  localparam logic [NPINS-1:0] DBG_PINS = 8'h1D;
  // configuration field codes
  localparam logic [3:0] CFG_ANALOG = 4'h0;
  localparam logic [3:0] CFG_IN_FLOAT = 4'h4;
  localparam logic [3:0] CFG_IN_PULL = 4'h8;
  localparam logic [3:0] CFG_OUT_PP = 4'h1;
  localparam logic [3:0] CFG_OUT_OD = 4'h5;
  localparam logic [3:0] CFG_SWD = 4'h6;
  localparam logic [3:0] CFG_ALT_PP = 4'h9;
  localparam logic [3:0] CFG_ALT_OD = 4'hD;
  localparam logic [3:0] CFG_SLAVE_OUT = 4'hB;
  // register word addresses
  localparam logic [3:0] ADDR_CFG_LO = 4'h0;
  localparam logic [3:0] ADDR_CFG_HI = 4'h1;
  localparam logic [3:0] ADDR_IN = 4'h2;
  localparam logic [3:0] ADDR_OUT = 4'h3;
  localparam logic [3:0] ADDR_SET = 4'h4;
  localparam logic [3:0] ADDR_CLR = 4'h5;
  localparam logic [3:0] ADDR_DBG_CFG = 4'h6;
  localparam logic [3:0] ADDR_DBG_STAT = 4'h7;
  localparam logic [3:0] ADDR_WAKE_EN = 4'h8;
  localparam logic [3:0] ADDR_WAKE_FILT = 4'h9;
  localparam logic [3:0] ADDR_WAKE_SEL = 4'hA;
  localparam logic [3:0] ADDR_WAKE_STAT = 4'hB;
  // field positions
  localparam int DBGCFG_DIS_BIT = 0;
  localparam int DBGCFG_REG_BIT = 1;
  localparam int DBGSTAT_BOOT_BIT = 0;
  localparam int DBGSTAT_MON_BIT = 1;
  localparam int FILT_PINS_BIT = 0;
  localparam int FILT_SC1_BIT = 1;
  localparam int FILT_SC2_BIT = 2;
  localparam int FILT_EXTERNAL_INTERRUPT_D_BIT = 3;
  localparam int NSRC = 4;
  localparam int WSEL_PIN_BIT = 0;
  localparam logic [31:0] CFG_RESET = 32'h44444444;
  localparam logic [1:0] DBGCFG_RESET = 2'h2;
  // timing
  localparam int STARTUP_CLKS = 512;
  localparam int CLK_MHZ = 100;
  localparam int MON_DELAY_MS = 3;
  localparam int MON_DELAY_CYC = MON_DELAY_MS * 1000 * 1000 * CLK_MHZ / 1000;
  localparam int SLOW_KHZ = 10;
  localparam int FILT_SAMPLES = 3;

  typedef enum logic [3:0] {
    GPB_ST_RESET = 4'h1,
    GPB_ST_STARTUP = 4'h2,
    GPB_ST_MONITOR = 4'h4,
    GPB_ST_RUN = 4'h8
  } gpb_boot_state_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } gpb_bus_req_t;

  typedef struct packed {
    logic [NPINS-1:0] out;
    logic [NPINS-1:0] oe;
    logic [NPINS-1:0] pull_up;
    logic [NPINS-1:0] pull_down;
  } gpb_pad_ctrl_t;
endpackage

// ==== hw/gpb_wake_filter.sv ====
// module: three-sample wake filter on the slow oscillator enable
`timescale 1ns/1ns
module gpb_wake_filter (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // control
  input wire logic slow_tick,
  input wire logic sleep_entry,
  input wire logic filt_en,
  input wire logic level,
  // result
  output logic wake
);
  logic ref_q;
  logic [gpb_pkg::FILT_SAMPLES-1:0] hist_q;
  logic [gpb_pkg::FILT_SAMPLES-1:0] all_diff;

  // reference level captured at sleep entry
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ref_q <= 1'b0;
    end else if (sleep_entry) begin
      ref_q <= level;
    end
  end

  // sample history advances only on the slow tick
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      hist_q <= '0;
    end else if (sleep_entry) begin
      hist_q <= {gpb_pkg::FILT_SAMPLES{level}};
    end else if (slow_tick) begin
      hist_q <= {hist_q[gpb_pkg::FILT_SAMPLES-2:0], level};
    end
  end

  assign all_diff = hist_q ^ {gpb_pkg::FILT_SAMPLES{ref_q}};
  // unfiltered wakes on any change; filtered needs three samples
  assign wake = filt_en ? (&all_diff) : (level != ref_q);
endmodule

// ==== hw/gpb_top.sv ====
// module: pad modes, boot select and wake monitor
// What this block does
// - boot select only after pin or power-on reset
// - boot pin pulled-up input through 512 startup ticks
// - sample boot pin once: high runs, low monitors
// - then boot pin floats
// - boot level held in status bit
// - monitor resamples after 3 ms
// - analog: no driver, no pulls, reads 1
// - floating: no pulls, no driver
// - pulled input: output bit picks pull
// - input sees pin level
// - forced debug owns its four pins
// - serial-wire kept on pin 4
// - output bit drives; atomic set and clear
// - zero sinks; one floats open-drain
// - outputs: no pulls, readback
// - alternate driven by peripheral
// - slave pin gated by select
// - any enabled pin change wakes
// - record pin wake, not which
// - filter: three equal differing samples
// - pin wake needs select; analog never
// - mode codes as listed
// - chip reset defaults
`timescale 1ns/1ns
module gpb_top #(
  parameter int MON_DELAY = gpb_pkg::MON_DELAY_CYC,
  parameter int SLOW_DIV = gpb_pkg::CLK_MHZ * 1000 / gpb_pkg::SLOW_KHZ
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // reset cause and startup oscillator
  input wire logic pin_or_por_reset,
  input wire logic fast_rc_oscillator_tick,
  // register port
  input wire gpb_pkg::gpb_bus_req_t bus_req,
  output logic [31:0] bus_rdata,
  // pads
  input wire logic [gpb_pkg::NPINS-1:0] pad_in,
  output gpb_pkg::gpb_pad_ctrl_t pad_ctrl,
  // peripherals
  input wire logic [gpb_pkg::NPINS-1:0] alt_out,
  input wire logic spi_slave_select_n,
  input wire logic dbg_forced_active,
  input wire logic [gpb_pkg::NPINS-1:0] dbg_out,
  input wire logic [gpb_pkg::NPINS-1:0] dbg_oe,
  output logic [gpb_pkg::NPINS-1:0] periph_in,
  output logic swd_keep,
  // power management
  input wire logic sleep_entry,
  input wire logic in_sleep,
  input wire logic serial_controller_1_act,
  input wire logic serial_controller_2_act,
  input wire logic external_interrupt_d,
  output logic wake_event,
  output logic boot_monitor_rom,
  output logic run_program
);
  localparam int SLOW_W = $clog2(SLOW_DIV + 1);
  localparam int MON_W = $clog2(MON_DELAY + 1);
  localparam int ST_W = $clog2(gpb_pkg::STARTUP_CLKS + 1);

  // ****************
  // input synchronisers
  // ****************
  logic [gpb_pkg::NPINS-1:0] s1_q, s2_q, s3_q;
  logic [gpb_pkg::NPINS-1:0] pin_lvl_q;
  // level moves when stages two and three agree
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      pin_lvl_q <= '0;
    end else begin
      s1_q <= pad_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      pin_lvl_q <= (s2_q & s3_q) | (pin_lvl_q & (s2_q | s3_q));
    end
  end

  // ****************
  // registers
  // ****************
  logic [31:0] cfg_q;
  logic [gpb_pkg::NPINS-1:0] out_q;
  logic [1:0] dbgcfg_q;
  logic [gpb_pkg::NPINS-1:0] wake_en_q;
  logic [gpb_pkg::NSRC-1:0] filt_q;
  logic wsel_q;
  logic boot_cap_q;
  logic pin_woke_q;
  logic [31:0] rdata_q;
  logic [gpb_pkg::NPINS-1:0] in_view;

  // configuration; no peripheral path
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q <= gpb_pkg::CFG_RESET;
    end else if (bus_req.wr && bus_req.addr == gpb_pkg::ADDR_CFG_LO) begin
      cfg_q[15:0] <= bus_req.wdata[15:0];
    end else if (bus_req.wr && bus_req.addr == gpb_pkg::ADDR_CFG_HI) begin
      cfg_q[31:16] <= bus_req.wdata[15:0];
    end
  end

  // output register with atomic set and clear
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_q <= '0;
    end else if (bus_req.wr) begin
      case (bus_req.addr)
        gpb_pkg::ADDR_OUT: out_q <= bus_req.wdata[gpb_pkg::NPINS-1:0];
        gpb_pkg::ADDR_SET: out_q <= out_q | bus_req.wdata[gpb_pkg::NPINS-1:0];
        gpb_pkg::ADDR_CLR: out_q <= out_q & ~bus_req.wdata[gpb_pkg::NPINS-1:0];
        default: out_q <= out_q;
      endcase
    end
  end

  // debug config; disable refused while debugger active
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      dbgcfg_q <= gpb_pkg::DBGCFG_RESET;
    end else if (bus_req.wr && bus_req.addr == gpb_pkg::ADDR_DBG_CFG) begin
      dbgcfg_q[gpb_pkg::DBGCFG_REG_BIT] <= bus_req.wdata[gpb_pkg::DBGCFG_REG_BIT];
      dbgcfg_q[gpb_pkg::DBGCFG_DIS_BIT] <= bus_req.wdata[gpb_pkg::DBGCFG_DIS_BIT] & ~dbg_forced_active;
    end
  end

  // wake controls
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wake_en_q <= '0;
      filt_q <= '0;
      wsel_q <= 1'b0;
    end else if (bus_req.wr) begin
      if (bus_req.addr == gpb_pkg::ADDR_WAKE_EN) begin
        wake_en_q <= bus_req.wdata[gpb_pkg::NPINS-1:0];
      end
      if (bus_req.addr == gpb_pkg::ADDR_WAKE_FILT) begin
        filt_q <= bus_req.wdata[gpb_pkg::NSRC-1:0];
      end
      if (bus_req.addr == gpb_pkg::ADDR_WAKE_SEL) begin
        wsel_q <= bus_req.wdata[gpb_pkg::WSEL_PIN_BIT];
      end
    end
  end

  // read mux; data stands one cycle after the strobe
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= '0;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        gpb_pkg::ADDR_CFG_LO: rdata_q <= {16'h0000, cfg_q[15:0]};
        gpb_pkg::ADDR_CFG_HI: rdata_q <= {16'h0000, cfg_q[31:16]};
        gpb_pkg::ADDR_IN: rdata_q <= {24'h000000, in_view};
        gpb_pkg::ADDR_OUT: rdata_q <= {24'h000000, out_q};
        gpb_pkg::ADDR_DBG_CFG: rdata_q <= {30'h00000000, dbgcfg_q};
        gpb_pkg::ADDR_DBG_STAT: rdata_q <= {30'h00000000, boot_monitor_rom, boot_cap_q};
        gpb_pkg::ADDR_WAKE_EN: rdata_q <= {24'h000000, wake_en_q};
        gpb_pkg::ADDR_WAKE_FILT: rdata_q <= {28'h0000000, filt_q};
        gpb_pkg::ADDR_WAKE_SEL: rdata_q <= {31'h00000000, wsel_q};
        gpb_pkg::ADDR_WAKE_STAT: rdata_q <= {31'h00000000, pin_woke_q};
        default: rdata_q <= '0;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end
  assign bus_rdata = rdata_q;

  // ****************
  // boot select sequencing
  // ****************
  gpb_pkg::gpb_boot_state_t st_q;
  logic [ST_W-1:0] st_cnt_q;
  logic [MON_W-1:0] mon_cnt_q;
  logic boot_honour_q;

  // reset cause caught after release
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= gpb_pkg::GPB_ST_RESET;
      st_cnt_q <= '0;
      mon_cnt_q <= '0;
      boot_honour_q <= 1'b0;
      boot_cap_q <= 1'b0;
    end else begin
      case (st_q)
        gpb_pkg::GPB_ST_RESET: begin
          boot_honour_q <= pin_or_por_reset;
          st_q <= gpb_pkg::GPB_ST_STARTUP;
        end
        gpb_pkg::GPB_ST_STARTUP: begin
          if (fast_rc_oscillator_tick) begin
            if (st_cnt_q == ST_W'(gpb_pkg::STARTUP_CLKS - 1)) begin
              // single sample; high normal, low monitor
              boot_cap_q <= pin_lvl_q[gpb_pkg::PIN_BOOT];
              if (boot_honour_q && !pin_lvl_q[gpb_pkg::PIN_BOOT]) begin
                st_q <= gpb_pkg::GPB_ST_MONITOR;
              end else begin
                st_q <= gpb_pkg::GPB_ST_RUN;
              end
            end else begin
              st_cnt_q <= st_cnt_q + 1'b1;
            end
          end
        end
        gpb_pkg::GPB_ST_MONITOR: begin
          // second look filters glitches
          if (mon_cnt_q == MON_W'(MON_DELAY - 1)) begin
            if (pin_lvl_q[gpb_pkg::PIN_BOOT]) begin
              st_q <= gpb_pkg::GPB_ST_RUN;
            end
          end else begin
            mon_cnt_q <= mon_cnt_q + 1'b1;
          end
        end
        gpb_pkg::GPB_ST_RUN: st_q <= gpb_pkg::GPB_ST_RUN;
        default: st_q <= gpb_pkg::GPB_ST_RESET;
      endcase
    end
  end
  logic in_startup;
  assign in_startup = (st_q == gpb_pkg::GPB_ST_RESET) || (st_q == gpb_pkg::GPB_ST_STARTUP);
  assign boot_monitor_rom = (st_q == gpb_pkg::GPB_ST_MONITOR) && (mon_cnt_q == MON_W'(MON_DELAY - 1));
  assign run_program = (st_q == gpb_pkg::GPB_ST_RUN);

  // ****************
  // per-pin pad decode
  // ****************
  logic dbg_forced;
  logic swd_mode;
  assign swd_mode = cfg_q[gpb_pkg::PIN_SWD*4 +: 4] == gpb_pkg::CFG_SWD;
  assign dbg_forced = ~dbgcfg_q[gpb_pkg::DBGCFG_DIS_BIT];
  assign swd_keep = dbgcfg_q[gpb_pkg::DBGCFG_DIS_BIT] & swd_mode;

  genvar gi;
  generate
    for (gi = 0; gi < gpb_pkg::NPINS; gi++) begin : g_pin
      logic [3:0] cfg;
      logic analog;
      logic drive;
      logic val;
      logic od;
      logic pull;
      logic dbg_own;
      assign cfg = cfg_q[gi*4 +: 4];
      assign dbg_own = gpb_pkg::DBG_PINS[gi] & (dbg_forced | (gi == gpb_pkg::PIN_SWD && swd_keep));
      assign analog = (cfg == gpb_pkg::CFG_ANALOG) & ~dbg_own;
      always_comb begin
        drive = 1'b0;
        val = 1'b0;
        od = 1'b0;
        pull = 1'b0;
        case (cfg)
          gpb_pkg::CFG_IN_PULL: pull = 1'b1;
          gpb_pkg::CFG_OUT_PP: begin drive = 1'b1; val = out_q[gi]; end
          gpb_pkg::CFG_OUT_OD: begin drive = 1'b1; val = out_q[gi]; od = 1'b1; end
          gpb_pkg::CFG_ALT_PP: begin drive = 1'b1; val = alt_out[gi]; end
          gpb_pkg::CFG_ALT_OD: begin drive = 1'b1; val = alt_out[gi]; od = 1'b1; end
          gpb_pkg::CFG_SLAVE_OUT: begin
            drive = (gi == gpb_pkg::PIN_MISO) && !spi_slave_select_n;
            val = alt_out[gi];
          end
          default: drive = 1'b0;
        endcase
      end
      // registered pad controls; pulls in pulled input, on the boot pin in startup and on undriven debug-owned pins other than the kept serial-wire pin
      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          pad_ctrl.out[gi] <= 1'b0;
          pad_ctrl.oe[gi] <= 1'b0;
          pad_ctrl.pull_up[gi] <= (gi == gpb_pkg::PIN_BOOT);
          pad_ctrl.pull_down[gi] <= 1'b0;
        end else if (gi == gpb_pkg::PIN_BOOT && in_startup) begin
          pad_ctrl.out[gi] <= 1'b0;
          pad_ctrl.oe[gi] <= 1'b0;
          pad_ctrl.pull_up[gi] <= 1'b1;
          pad_ctrl.pull_down[gi] <= 1'b0;
        end else if (dbg_own) begin
          pad_ctrl.out[gi] <= dbg_out[gi];
          pad_ctrl.oe[gi] <= dbg_oe[gi];
          pad_ctrl.pull_up[gi] <= ~dbg_oe[gi] & (gi != gpb_pkg::PIN_SWD || !swd_keep);
          pad_ctrl.pull_down[gi] <= 1'b0;
        end else begin
          pad_ctrl.out[gi] <= val;
          pad_ctrl.oe[gi] <= drive & ~(od & val);
          pad_ctrl.pull_up[gi] <= pull & out_q[gi];
          pad_ctrl.pull_down[gi] <= pull & ~out_q[gi];
        end
      end
      assign in_view[gi] = analog ? 1'b1 : pin_lvl_q[gi];
      assign periph_in[gi] = in_view[gi];
    end
  endgenerate

  // ****************
  // wake monitor
  // ****************
  logic [SLOW_W-1:0] slow_cnt_q;
  logic slow_tick;
  // slow sample enable for the filters
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      slow_cnt_q <= '0;
    end else if (slow_cnt_q == SLOW_W'(SLOW_DIV - 1)) begin
      slow_cnt_q <= '0;
    end else begin
      slow_cnt_q <= slow_cnt_q + 1'b1;
    end
  end
  assign slow_tick = slow_cnt_q == SLOW_W'(SLOW_DIV - 1);

  logic [gpb_pkg::NPINS-1:0] pin_wake;
  logic [gpb_pkg::NSRC-2:0] src_wake;
  logic [gpb_pkg::NSRC-2:0] src_lvl;
  assign src_lvl = {external_interrupt_d, serial_controller_2_act, serial_controller_1_act};

  generate
    for (gi = 0; gi < gpb_pkg::NPINS; gi++) begin : g_pwake
      gpb_wake_filter u_filt (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .slow_tick(slow_tick),
        .sleep_entry(sleep_entry),
        .filt_en(filt_q[gpb_pkg::FILT_PINS_BIT]),
        .level(in_view[gi]),
        .wake(pin_wake[gi])
      );
    end
    for (gi = 0; gi < gpb_pkg::NSRC - 1; gi++) begin : g_swake
      gpb_wake_filter u_filt (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .slow_tick(slow_tick),
        .sleep_entry(sleep_entry),
        .filt_en(filt_q[gi + gpb_pkg::FILT_SC1_BIT]),
        .level(src_lvl[gi]),
        .wake(src_wake[gi])
      );
    end
  endgenerate

  logic any_pin_wake;
  assign any_pin_wake = in_sleep & wsel_q & |(pin_wake & wake_en_q);
  assign wake_event = any_pin_wake | (in_sleep & |src_wake);

  // sticky, no pin identity; sleep clears, wake wins
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_woke_q <= 1'b0;
    end else if (any_pin_wake) begin
      pin_woke_q <= 1'b1;
    end else if (sleep_entry) begin
      pin_woke_q <= 1'b0;
    end
  end
endmodule

// ==== test/gpb_top_assertions.sv ====
// checker: pad, boot and wake properties seen at the block ports
`timescale 1ns/1ns
module gpb_top_checker #(
  parameter int MON_DELAY = 20,
  parameter int SLOW_DIV = 4
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // inputs of the block
  input wire logic fast_rc_oscillator_tick,
  input wire gpb_pkg::gpb_bus_req_t bus_req,
  input wire logic [7:0] alt_out,
  input wire logic spi_slave_select_n,
  input wire logic in_sleep,
  // outputs of the block
  input wire gpb_pkg::gpb_pad_ctrl_t pad_ctrl,
  input wire logic [7:0] periph_in,
  input wire logic wake_event,
  input wire logic boot_monitor_rom,
  input wire logic run_program
);
  logic [9:0] ticks_q;
  logic [2:0] age_q;
  logic [15:0] cfg_lo_q, cfg_hi_q;
  logic [7:0] out_q;
  logic sel_q;
  wire [3:0] f1 = cfg_lo_q[7:4];
  wire [3:0] f6 = cfg_hi_q[11:8];
  wire quiet = age_q > 3'h3;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  // startup ticks, saturating at 512
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ticks_q <= 10'h000;
    end else if (fast_rc_oscillator_tick && ticks_q != 10'h200) begin
      ticks_q <= ticks_q + 10'h001;
    end
  end
  // cycles since a write; pads lag two edges
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b || bus_req.wr) begin
      age_q <= 3'h0;
    end else if (age_q != 3'h7) begin
      age_q <= age_q + 3'h1;
    end
  end
  // shadow of pin 1 and 6 controls
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_lo_q <= 16'h4444;
      cfg_hi_q <= 16'h4444;
      out_q <= 8'h00;
      sel_q <= 1'b0;
    end else if (bus_req.wr) begin
      case (bus_req.addr)
        gpb_pkg::ADDR_CFG_LO: cfg_lo_q <= bus_req.wdata[15:0];
        gpb_pkg::ADDR_CFG_HI: cfg_hi_q <= bus_req.wdata[15:0];
        gpb_pkg::ADDR_OUT: out_q <= bus_req.wdata[7:0];
        gpb_pkg::ADDR_SET: out_q <= out_q | bus_req.wdata[7:0];
        gpb_pkg::ADDR_CLR: out_q <= out_q & ~bus_req.wdata[7:0];
        gpb_pkg::ADDR_WAKE_SEL: sel_q <= bus_req.wdata[0];
        default: ;
      endcase
    end
  end
  // ****************
  // properties
  // ****************
  sequence settled;
    (quiet && $stable(alt_out) && $stable(spi_slave_select_n))[*3];
  endsequence
  sequence startup_done;
    (ticks_q == 10'h200)[*4];
  endsequence
  chk_boot_pullup: assert property (ticks_q != 10'h200 |-> pad_ctrl.pull_up[5] && !pad_ctrl.oe[5])
    else $error("boot pin not pulled up");
  chk_boot_release: assert property (startup_done |-> !pad_ctrl.pull_up[5])
    else $error("boot pin still pulled");
  chk_analog_idle: assert property (quiet && f6 == gpb_pkg::CFG_ANALOG |->
    !pad_ctrl.oe[6] && !pad_ctrl.pull_up[6] && !pad_ctrl.pull_down[6] && periph_in[6]) else $error("analog pin active");
  chk_float_hiz: assert property (quiet && (f6 == 4'h4 || f6 == 4'h3) |->
    !pad_ctrl.oe[6] && !pad_ctrl.pull_up[6] && !pad_ctrl.pull_down[6]) else $error("floating pin not quiet");
  chk_pull_dir: assert property (quiet && f6 == gpb_pkg::CFG_IN_PULL |-> !pad_ctrl.oe[6] &&
    pad_ctrl.pull_up[6] == out_q[6] && pad_ctrl.pull_down[6] == !out_q[6]) else $error("wrong pull direction");
  chk_out_drive: assert property (quiet && f6 == gpb_pkg::CFG_OUT_PP |->
    pad_ctrl.oe[6] && pad_ctrl.out[6] == out_q[6] && !pad_ctrl.pull_up[6]) else $error("push-pull output wrong");
  chk_od_sink: assert property (quiet && f6 == gpb_pkg::CFG_OUT_OD |-> pad_ctrl.oe[6] == !out_q[6] &&
    !(pad_ctrl.oe[6] && pad_ctrl.out[6]) && !pad_ctrl.pull_down[6]) else $error("open-drain output wrong");
  chk_alt_drive: assert property (settled ##0 f6 == gpb_pkg::CFG_ALT_PP |->
    pad_ctrl.oe[6] && pad_ctrl.out[6] == alt_out[6]) else $error("alternate output wrong");
  chk_slave_gate: assert property (settled ##0 f1 == gpb_pkg::CFG_SLAVE_OUT |->
    pad_ctrl.oe[1] == !spi_slave_select_n && (spi_slave_select_n || pad_ctrl.out[1] == alt_out[1]))
    else $error("slave gate wrong");
  chk_wake_gate: assert property (wake_event |-> in_sleep && sel_q)
    else $error("stray wake");
  chk_boot_excl: assert property (!(run_program && boot_monitor_rom))
    else $error("monitor and program both");
endmodule
bind gpb_top gpb_top_checker #(.MON_DELAY(MON_DELAY), .SLOW_DIV(SLOW_DIV)) gpb_top_checker_inst (
  .core_clk(core_clk), .rst_b(rst_b), .fast_rc_oscillator_tick(fast_rc_oscillator_tick), .bus_req(bus_req),
  .alt_out(alt_out), .spi_slave_select_n(spi_slave_select_n), .in_sleep(in_sleep), .pad_ctrl(pad_ctrl),
  .periph_in(periph_in), .wake_event(wake_event), .boot_monitor_rom(boot_monitor_rom), .run_program(run_program)
);

// ==== test/gpb_pad_model.sv ====
// partner model: board circuitry that settles each pad level
`timescale 1ns/1ns
module gpb_pad_model (
  // clock
  input wire logic core_clk,
  // board drivers
  input wire logic [7:0] board_en,
  input wire logic [7:0] board_val,
  // pads
  input wire gpb_pkg::gpb_pad_ctrl_t pad_ctrl,
  output logic [7:0] pad_in
);
  logic flip_q = 1'b0;
  // an undriven, unpulled pad wanders so a stale level never passes
  always @(posedge core_clk) begin
    flip_q <= ~flip_q;
  end
  // the chip driver wins, then the board, then the pull resistors
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad_ctrl.oe[i]) begin
        pad_in[i] = pad_ctrl.out[i];
      end else if (board_en[i]) begin
        pad_in[i] = board_val[i];
      end else if (pad_ctrl.pull_up[i] | pad_ctrl.pull_down[i]) begin
        pad_in[i] = pad_ctrl.pull_up[i];
      end else begin
        pad_in[i] = flip_q;
      end
    end
  end
endmodule

// ==== test/tb_gpb_top.sv ====
// testbench: boot, pad mode, debug and wake scenarios for the pad block
`timescale 1ns/1ns
module tb_gpb_top;
  logic core_clk, swd_keep, wake_event, mon, run;
  logic rst_b = 1'b0, por = 1'b1, tick = 1'b0, sel_n = 1'b1, forced = 1'b0, sleep_entry = 1'b0, in_sleep = 1'b0;
  logic [7:0] alt_out = 8'h00, dbg_out = 8'h00, dbg_oe = 8'h00, board_en = 8'h20, board_val = 8'h00;
  logic [7:0] pad_in, periph_in;
  logic [31:0] bus_rdata;
  logic [31:0] rng = 32'h2B97;
  logic rd_seen = 1'b0;
  logic [63:0] note;
  logic [63:0] exp_q[$];
  gpb_pkg::gpb_bus_req_t bus_req = '0;
  gpb_pkg::gpb_pad_ctrl_t pad_ctrl;
  int errors = 0;
  int checks = 0;
  localparam logic [3:0] CODES [8] = '{4'h0, 4'h4, 4'h8, 4'h1, 4'h5, 4'h9, 4'hD, 4'h3};
  gpb_top #(.MON_DELAY(40), .SLOW_DIV(4)) gpb_top_inst (
    .core_clk(core_clk), .rst_b(rst_b), .pin_or_por_reset(por), .fast_rc_oscillator_tick(tick),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .pad_in(pad_in), .pad_ctrl(pad_ctrl), .alt_out(alt_out),
    .spi_slave_select_n(sel_n), .dbg_forced_active(forced), .dbg_out(dbg_out), .dbg_oe(dbg_oe),
    .periph_in(periph_in), .swd_keep(swd_keep), .sleep_entry(sleep_entry), .in_sleep(in_sleep),
    .serial_controller_1_act(1'b0), .serial_controller_2_act(1'b0), .external_interrupt_d(1'b0),
    .wake_event(wake_event), .boot_monitor_rom(mon), .run_program(run));
  gpb_pad_model gpb_pad_model_inst (.core_clk(core_clk), .board_en(board_en), .board_val(board_val),
    .pad_ctrl(pad_ctrl), .pad_in(pad_in));
  // clock; oscillator tick every other cycle
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    tick <= ~tick;
    rd_seen <= bus_req.rd;
  end
  function automatic logic [31:0] nxt(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction
  // expected {oe, driven one, pull_up, pull_down} of one pad
  function automatic logic [3:0] pad_exp(input logic [3:0] c, input logic ob, input logic al);
    case (c)
      4'h8: return {2'b00, ob, ~ob};
      4'h1: return {1'b1, ob, 2'b00};
      4'h5: return {~ob, 3'b000};
      4'h9: return {1'b1, al, 2'b00};
      4'hD: return {~al, 3'b000};
      default: return 4'h0;
    endcase
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // cyc drops the strobes
  task automatic cyc(input int n);
    bus_req <= '0;
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    exp_q.push_back({m, e});
    @(posedge core_clk);
  endtask
  // read data taken mid-cycle
  always @(negedge core_clk) begin
    if (rd_seen === 1'b1) begin
      note = exp_q.pop_front();
      check("bus_rdata", bus_rdata & note[63:32], note[31:0]);
    end
  end
  task automatic boot_case(input logic src, input logic rise, input logic mon_e);
    rst_b <= 1'b0;
    por <= src;
    board_en <= 8'h20;
    board_val <= 8'h00;
    cyc(20);
    rst_b <= 1'b1;
    cyc(1);
    check("boot_pull", pad_ctrl.pull_up[5], 1'b1);
    rd(4'h0, 32'h4444, 32'hFFFF);
    rd(4'h1, 32'h4444, 32'hFFFF);
    rd(4'h6, 32'h2, 32'h3);
    rd(4'hF, 32'h0, 32'hFFFFFFFF);
    cyc(1036);
    check("boot_release", pad_ctrl.pull_up[5], 1'b0);
    if (src) begin
      wr(4'h7, 32'h1);
      rd(4'h7, 32'h0, 32'h1);
    end
    board_val[5] <= rise;
    cyc(80);
    check("monitor", mon, mon_e);
    check("run", run, !mon_e);
  endtask
  // ****************
  // scenarios
  // ****************
  initial begin
    logic [3:0] e;
    logic got;
    @(posedge core_clk);
    boot_case(1'b1, 1'b0, 1'b1);
    boot_case(1'b1, 1'b1, 1'b0);
    boot_case(1'b0, 1'b0, 1'b0);
    board_en <= 8'h40;
    // seven mode codes (not 6 or B) and unused code 3, both output bits
    for (int i = 0; i < 16; i++) begin
      rng = nxt(rng);
      alt_out <= rng[7:0];
      board_val <= rng[15:8];
      wr(4'h1, {16'h0, 4'h4, CODES[i / 2], 8'h44});
      wr(4'h3, {25'h0, i[0], 6'h0});
      cyc(8);
      e = pad_exp(CODES[i / 2], i[0], rng[6]);
      check("pad6", {pad_ctrl.oe[6], pad_ctrl.oe[6] & pad_ctrl.out[6], pad_ctrl.pull_up[6], pad_ctrl.pull_down[6]}, e);
      got = (CODES[i / 2] == 4'h0) ? 1'b1 : (e[3] ? e[2] : rng[14]);
      check("periph6", periph_in[6], got);
      rd(4'h2, {25'h0, got, 6'h0}, 32'h40);
      rd(4'h3, {25'h0, i[0], 6'h0}, 32'h40);
    end
    // set, clear, read back
    for (int i = 0; i < 4; i++) begin
      rng = nxt(rng);
      wr(4'h3, {24'h0, rng[7:0]});
      wr(4'h4, {24'h0, rng[15:8]});
      wr(4'h5, {24'h0, rng[23:16]});
      rd(4'h3, {24'h0, (rng[7:0] | rng[15:8]) & ~rng[23:16]}, 32'hFF);
    end
    wr(4'h0, 32'h44B1);
    for (int s = 0; s < 2; s++) begin
      sel_n <= s[0];
      cyc(6);
      check("slave_oe", pad_ctrl.oe[1], !s[0]);
    end
    // debug-disable refused while forced
    wr(4'h3, 32'h1);
    forced <= 1'b1;
    wr(4'h6, 32'h3);
    rd(4'h6, 32'h2, 32'h3);
    cyc(6);
    check("dbg_pin0", pad_ctrl.oe[0], 1'b0);
    check("swd_keep", swd_keep, 1'b0);
    forced <= 1'b0;
    wr(4'h6, 32'h3);
    wr(4'h1, 32'h4446);
    rd(4'h6, 32'h3, 32'h3);
    cyc(6);
    check("gpio_pin0", {pad_ctrl.oe[0], pad_ctrl.out[0]}, 2'b11);
    check("swd_keep", swd_keep, 1'b1);
    // wake: plain, filtered, deselected
    board_en <= 8'hC0;
    wr(4'h1, 32'h4444);
    wr(4'h8, 32'h40);
    for (int k = 0; k < 3; k++) begin
      wr(4'h9, {31'h0, k == 1});
      wr(4'hA, {31'h0, k != 2});
      board_val <= 8'h00;
      cyc(8);
      sleep_entry <= 1'b1;
      cyc(1);
      sleep_entry <= 1'b0;
      in_sleep <= 1'b1;
      board_val <= 8'h80;
      cyc(20);
      check("wake_quiet", wake_event, 1'b0);
      board_val <= 8'hC0;
      got = 1'b0;
      for (int t = 0; t < 60 && !got; t++) begin
        @(posedge core_clk);
        got = wake_event === 1'b1;
      end
      check("wake", got, k != 2);
      rd(4'hB, {31'h0, k != 2}, 32'h1);
      in_sleep <= 1'b0;
      cyc(4);
    end
    report_and_stop();
  end
  // hang fails
  initial begin
    repeat (30000) @(posedge core_clk);
    errors++;
    report_and_stop();
  end
endmodule
